// [tims_top.sv]
// Mode selection, command steering and front indicators of the tag interface.
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps

module tims_top
	import tims_pkg::*;
#(
	parameter int unsigned FLASH_CYCLES = FLASH_CYC
) (
	input  wire logic        core_clk,          // System clock, 200 MHz
	input  wire logic        rstn,              // Asynchronous reset, active low
	input  wire logic [7:0]  avs_address,       // Avalon byte address
	input  wire logic        avs_read,          // Avalon read request
	input  wire logic        avs_write,         // Avalon write request
	input  wire logic [31:0] avs_writedata,     // Avalon write data
	input  wire logic [3:0]  avs_byteenable,    // Avalon byte enables
	output logic [31:0]      avs_readdata,      // Avalon read data
	output logic             avs_waitrequest,   // Avalon wait request
	output logic             irq,               // Level interrupt
	input  wire logic [3:0]  mode_switch,       // Front rotary switch pin
	input  wire logic        supply_24v_ok,     // External supply present pin
	input  wire logic        hw_fault,          // Module hardware fault pin
	input  wire logic        reader_done,       // Reader dialog finished pin
	input  wire logic        reader_error,      // Reader dialog error pin
	input  wire logic        tag_in_field,      // Tag in reader field pin
	output logic [1:0]       reader_op,         // Operation started on reader
	output logic             reader_start,      // Start pulse to reader logic
	output logic             strict_check,      // Strict error checking on
	output logic             ecc_enable,        // Error-correction driver on
	output logic             tester_enable,     // Handheld tester port on
	output logic             host_frames_en,    // Host frames accepted
	output logic             error_led,         // Red indicator
	output logic             dialog_led,        // Yellow indicator
	output logic             presence_led,      // Green presence indicator
	output logic             first_reader_led,  // First reader active
	output logic             second_reader_led, // Second reader active
	output logic             power_led          // Power indicator
);

	// Two-flop synchronisers for all pin inputs.
	localparam int unsigned PW = 9;
	logic [PW-1:0] pin_raw, pin_s1, pin_s2;
	assign pin_raw = {mode_switch, supply_24v_ok, hw_fault, reader_done, reader_error,
		tag_in_field};
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
		end
	end
	logic [3:0] sw;
	logic       pwr, fault, done_p, err_p, tag_p;
	assign {sw, pwr, fault, done_p, err_p, tag_p} = pin_s2;

	// Mode decode.
	logic tester_mode, is_init, mode_valid;
	assign tester_mode = sw[3];
	assign is_init = (sw == SW_INIT) || (sw == SW_INIT_ECC);
	assign mode_valid = (sw == SW_NORMAL) || (sw == SW_ECC) || (sw == SW_TEST)
		|| (sw == SW_TEST_ECC) || is_init;

	// State of registers.
	logic [31:0] ctrl, next_ctrl;
	logic [EV_W-1:0] ev_st, next_ev_st, ev_msk, next_ev_msk;
	logic [7:0] img_in [IMG_IN_BYTES];
	logic [7:0] img_out [IMG_OUT_BYTES];
	logic [7:0] next_img_out [IMG_OUT_BYTES];
	logic [31:0] next_rdata;
	logic        ack, next_ack;
	logic [3:0]  sw_q, next_sw_q;
	tims_state_t st, next_st;
	tims_op_t    op, next_op;
	logic        start, next_start;
	logic        last_err, next_last_err;
	logic        tag_q, next_tag_q;
	logic        done_q, next_done_q;
	logic        cmd_wr;
	logic [1:0]  cmd_code;

	// Image input bytes reflect block state back to the host.
	always_comb begin
		for (int i = 0; i < IMG_IN_BYTES; i++) begin
			img_in[i] = '0;
		end
		img_in[0] = {2'b00, op, sw};
		img_in[1] = {5'b0_0000, last_err, st == TIMS_BUSY, tag_p};
	end

	logic rd_hit, wr_hit;
	assign rd_hit = avs_read && !ack;
	// A write lands at the edge where waitrequest is seen low, the one edge the master trusts.
	assign wr_hit = avs_write && ack;
	assign cmd_wr = wr_hit && (avs_address == OFS_IMG_OUT) && avs_byteenable[0];
	assign cmd_code = avs_writedata[1:0];

	always_comb begin
		next_ctrl   = ctrl;
		next_ev_msk = ev_msk;
		next_rdata  = 32'h0000_0000;
		next_ack    = (avs_read || avs_write) && !ack;
		for (int i = 0; i < IMG_OUT_BYTES; i++) begin
			next_img_out[i] = img_out[i];
		end
		if (wr_hit) begin
			unique case (avs_address)
				OFS_CTRL: begin
					if (avs_byteenable[0]) next_ctrl[7:0] = avs_writedata[7:0];
				end
				OFS_IRQ_MSK: begin
					if (avs_byteenable[0]) next_ev_msk = avs_writedata[EV_W-1:0];
				end
				OFS_IMG_OUT, OFS_IMG_OUT + 8'h04: begin
					for (int b = 0; b < 4; b++) begin
						if (avs_byteenable[b])
							next_img_out[{avs_address[2], 2'(b)}] = avs_writedata[8*b +: 8];
					end
				end
				default: begin
				end
			endcase
		end
		if (rd_hit) begin
			unique case (avs_address)
				OFS_CTRL:    next_rdata = ctrl;
				OFS_STATUS:  next_rdata = {24'h00_0000, 4'(sw), 1'b0, tester_mode, st == TIMS_BUSY,
					last_err};
				OFS_IRQ_ST:  next_rdata = {28'h000_0000, ev_st};
				OFS_IRQ_MSK: next_rdata = {28'h000_0000, ev_msk};
				OFS_IMG_IN:  next_rdata = {img_in[3], img_in[2], img_in[1], img_in[0]};
				OFS_IMG_IN + 8'h04: next_rdata = {img_in[7], img_in[6], img_in[5], img_in[4]};
				OFS_IMG_OUT: next_rdata = {img_out[3], img_out[2], img_out[1], img_out[0]};
				OFS_IMG_OUT + 8'h04: next_rdata = {img_out[7], img_out[6], img_out[5], img_out[4]};
				OFS_FOOT:    next_rdata = 32'(IMG_TOTAL);
				default:     next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// Command sequencer: a host write of the command byte starts a dialog.
	always_comb begin
		next_st       = st;
		next_op       = op;
		next_start    = 1'b0;
		next_last_err = last_err;
		next_sw_q     = sw;
		next_tag_q    = tag_p;
		next_done_q   = done_p;
		unique case (st)
			TIMS_IDLE: begin
				if (cmd_wr && !tester_mode && mode_valid && cmd_code != CMD_NONE) begin
					next_st    = TIMS_BUSY;
					next_start = 1'b1;
					if (cmd_code == CMD_WRITE && is_init) next_op = TIMS_OP_INIT;
					else if (cmd_code == CMD_WRITE) next_op = TIMS_OP_WRITE;
					else next_op = TIMS_OP_READ;
				end
			end
			TIMS_BUSY: begin
				if (done_p && !done_q) begin
					next_st       = TIMS_FINISH;
					next_last_err = err_p;
				end
			end
			TIMS_FINISH: begin
				next_st = TIMS_IDLE;
				next_op = TIMS_OP_NONE;
			end
			default: next_st = TIMS_IDLE;
		endcase
	end

	// Sticky events; a set in the same cycle as the clearing read wins.
	logic [EV_W-1:0] ev_set;
	always_comb begin
		ev_set = '0;
		ev_set[EV_DONE]   = (st == TIMS_FINISH);
		ev_set[EV_ERROR]  = (st == TIMS_FINISH) && last_err;
		ev_set[EV_TAG_IN] = tag_p && !tag_q;
		ev_set[EV_MODE]   = (sw != sw_q);
		next_ev_st = ev_st;
		if (rd_hit && avs_address == OFS_IRQ_ST) next_ev_st = '0;
		next_ev_st = next_ev_st | ev_set;
	end

	// Pseudo-random flash pacing for the dialog indicator.
	logic [31:0] fl_cnt, next_fl_cnt;
	logic [LFSR_W-1:0] lfsr, next_lfsr;
	logic blink, next_blink;
	always_comb begin
		next_fl_cnt = fl_cnt + 32'h0000_0001;
		next_lfsr   = lfsr;
		next_blink  = blink;
		if (fl_cnt >= 32'(FLASH_CYCLES) * {24'h00_0000, lfsr[3:0] | 8'h01}) begin
			next_fl_cnt = 32'h0000_0000;
			next_lfsr   = {lfsr[LFSR_W-2:0], ^(lfsr & LFSR_TAPS)};
			next_blink  = !blink;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl     <= CTRL_RESET;
			ev_st    <= '0;
			ev_msk   <= '0;
			avs_readdata <= 32'h0000_0000;
			ack      <= 1'b0;
			st       <= TIMS_IDLE;
			op       <= TIMS_OP_NONE;
			start    <= 1'b0;
			last_err <= 1'b0;
			sw_q     <= 4'h0;
			tag_q    <= 1'b0;
			done_q   <= 1'b0;
			fl_cnt   <= 32'h0000_0000;
			lfsr     <= LFSR_SEED;
			blink    <= 1'b0;
			for (int i = 0; i < IMG_OUT_BYTES; i++) img_out[i] <= 8'h00;
		end else begin
			ctrl     <= next_ctrl;
			ev_st    <= next_ev_st;
			ev_msk   <= next_ev_msk;
			avs_readdata <= next_rdata;
			ack      <= next_ack;
			st       <= next_st;
			op       <= next_op;
			start    <= next_start;
			last_err <= next_last_err;
			sw_q     <= next_sw_q;
			tag_q    <= next_tag_q;
			done_q   <= next_done_q;
			fl_cnt   <= next_fl_cnt;
			lfsr     <= next_lfsr;
			blink    <= next_blink;
			for (int i = 0; i < IMG_OUT_BYTES; i++) img_out[i] <= next_img_out[i];
		end
	end

	// Every access answers one cycle after it is presented.
	assign avs_waitrequest = (avs_read || avs_write) && !ack;
	assign irq = |(ev_st & ev_msk);
	assign reader_op = op;
	assign reader_start = start;
	assign strict_check = (sw == SW_TEST) || (sw == SW_TEST_ECC);
	assign ecc_enable = (sw == SW_ECC) || (sw == SW_TEST_ECC) || (sw == SW_INIT_ECC);
	assign tester_enable = tester_mode;
	assign host_frames_en = !tester_mode;
	assign error_led = last_err || fault;
	assign dialog_led = ctrl[CTRL_PRES_EN] || ((st == TIMS_BUSY) && blink);
	assign presence_led = ctrl[CTRL_PRES_EN] && tag_p;
	assign first_reader_led = (st == TIMS_BUSY) && !ctrl[CTRL_READER];
	assign second_reader_led = (st == TIMS_BUSY) && ctrl[CTRL_READER];
	assign power_led = pwr;

	tester_block_a: assert property (@(posedge core_clk) disable iff (!rstn)
		tester_mode |-> !next_start) else $error("start in tester mode");
	reserved_block_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!mode_valid |-> !next_start) else $error("start in reserved mode");
	init_conv_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(st == TIMS_IDLE && cmd_wr && is_init && cmd_code == CMD_WRITE && !tester_mode)
		|=> (op == TIMS_OP_INIT && start)) else $error("write not turned into init");
	reader_one_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!(first_reader_led && second_reader_led)) else $error("both reader LEDs lit");
	error_lamp_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(last_err || fault) |-> error_led) else $error("error lamp dark");
	presence_lamp_a: assert property (@(posedge core_clk) disable iff (!rstn)
		presence_led |-> (tag_p && ctrl[CTRL_PRES_EN])) else $error("presence lamp wrong");
	dialog_steady_a: assert property (@(posedge core_clk) disable iff (!rstn)
		ctrl[CTRL_PRES_EN] |-> dialog_led) else $error("yellow not steady");
	port_excl_a: assert property (@(posedge core_clk) disable iff (!rstn)
		tester_enable != host_frames_en) else $error("ports both on or off");
	strict_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(sw == SW_TEST) |-> (strict_check && !ecc_enable)) else $error("strict mode wrong");
	ecc_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(sw == SW_TEST_ECC || sw == SW_INIT_ECC) |-> ecc_enable) else $error("ecc off");
	power_lamp_a: assert property (@(posedge core_clk) disable iff (!rstn)
		$rose(pwr) |-> power_led) else $error("power lamp dark");

endmodule : tims_top

// [tims_pkg.sv]
// Package of constants and types for the tag interface mode and status block.
package tims_pkg;

	// Process-image window: eight input plus eight output bytes.
	localparam int unsigned IMG_IN_BYTES  = 8;
	localparam int unsigned IMG_OUT_BYTES = 8;
	localparam int unsigned IMG_TOTAL     = IMG_IN_BYTES + IMG_OUT_BYTES;

	// Register word offsets (byte addresses on the Avalon bus).
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_STATUS  = 8'h04;
	localparam logic [7:0] OFS_IRQ_ST  = 8'h08;
	localparam logic [7:0] OFS_IRQ_MSK = 8'h0C;
	localparam logic [7:0] OFS_IMG_IN  = 8'h10;
	localparam logic [7:0] OFS_IMG_OUT = 8'h18;
	localparam logic [7:0] OFS_FOOT    = 8'h20;

	// Control register fields.
	localparam int unsigned CTRL_PRES_EN = 0;
	localparam int unsigned CTRL_READER  = 1;
	localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

	// Event bits, shared by the sticky status and the mask register.
	localparam int unsigned EV_DONE   = 0;
	localparam int unsigned EV_ERROR  = 1;
	localparam int unsigned EV_TAG_IN = 2;
	localparam int unsigned EV_MODE   = 3;
	localparam int unsigned EV_W      = 4;

	// Switch positions.
	localparam logic [3:0] SW_NORMAL    = 4'h0;
	localparam logic [3:0] SW_TEST      = 4'h2;
	localparam logic [3:0] SW_TEST_ECC  = 4'h3;
	localparam logic [3:0] SW_INIT      = 4'h4;
	localparam logic [3:0] SW_INIT_ECC  = 4'h5;
	localparam logic [3:0] SW_ECC       = 4'h1;
	localparam logic [3:0] SW_TESTER_LO = 4'h8;

	// Command codes from the host image.
	localparam logic [1:0] CMD_NONE  = 2'h0;
	localparam logic [1:0] CMD_READ  = 2'h1;
	localparam logic [1:0] CMD_WRITE = 2'h2;

	// Flash timing of the dialog indicator.
	localparam int unsigned CLK_MHZ      = 200;
	localparam int unsigned FLASH_BASE_US = 20;
	localparam int unsigned FLASH_CYC    = FLASH_BASE_US * CLK_MHZ;
	localparam int unsigned LFSR_W       = 8;
	localparam logic [LFSR_W-1:0] LFSR_SEED = 8'hA5;
	localparam logic [LFSR_W-1:0] LFSR_TAPS = 8'hB8;

	typedef enum logic [1:0] {
		TIMS_IDLE,
		TIMS_BUSY,
		TIMS_FINISH
	} tims_state_t;

	typedef enum logic [1:0] {
		TIMS_OP_NONE,
		TIMS_OP_READ,
		TIMS_OP_WRITE,
		TIMS_OP_INIT
	} tims_op_t;

endpackage : tims_pkg

// [tims_reader_model.sv]
// Behavioural reader head that answers each start pulse after a chosen latency.
`timescale 1ns/1ps
module tims_reader_model (
	input  wire logic       core_clk,     // System clock
	input  wire logic       rstn,         // Asynchronous reset, active low
	input  wire logic       reader_start, // Start pulse from the block
	input  wire logic [4:0] lat,          // Cycles before the dialog ends
	input  wire logic       err,          // End the dialog with an error
	input  wire logic       tag,          // A tag sits in the field
	output logic            reader_done,  // Dialog finished pin
	output logic            reader_error, // Dialog error pin
	output logic            tag_in_field  // Tag presence pin
);
	logic [4:0] cnt;
	logic       busy;
	assign tag_in_field = tag;
	// The error pin is low outside the done cycle, as a real head releases it.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= 5'h0;
			busy <= 1'b0;
			reader_done <= 1'b0;
			reader_error <= 1'b0;
		end else if (reader_start) begin
			busy <= 1'b1;
			cnt <= lat;
		end else if (busy && cnt == 5'h0) begin
			busy <= 1'b0;
			reader_done <= 1'b1;
			reader_error <= err;
		end else begin
			cnt <= cnt - 5'h1;
			reader_done <= 1'b0;
			reader_error <= 1'b0;
		end
	end
endmodule : tims_reader_model

// [tb.sv]
// Self-checking bench of the mode, command steering and indicator block.
`timescale 1ns/1ps
module tb;
	import tims_pkg::*;
	logic core_clk, rstn, avs_read, avs_write, avs_waitrequest, irq;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable, mode_switch;
	logic supply_24v_ok, hw_fault, reader_done, reader_error, tag_in_field;
	logic [1:0] reader_op, seen_op, e_op;
	logic reader_start, strict_check, ecc_enable, tester_enable, host_frames_en;
	logic error_led, dialog_led, presence_led, first_reader_led, second_reader_led, power_led;
	logic [4:0] lat;
	logic err, tag, dlast;
	logic [15:0] lfsr_state;
	int fail_count, n_compared, starts, toggles;

	// A one-cycle flash base makes the indicator toggle within even the shortest dialog.
	tims_top #(.FLASH_CYCLES(1)) tims_top_inst (.core_clk(core_clk), .rstn(rstn),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
		.mode_switch(mode_switch), .supply_24v_ok(supply_24v_ok), .hw_fault(hw_fault),
		.reader_done(reader_done), .reader_error(reader_error), .tag_in_field(tag_in_field),
		.reader_op(reader_op), .reader_start(reader_start), .strict_check(strict_check),
		.ecc_enable(ecc_enable), .tester_enable(tester_enable),
		.host_frames_en(host_frames_en), .error_led(error_led), .dialog_led(dialog_led),
		.presence_led(presence_led), .first_reader_led(first_reader_led),
		.second_reader_led(second_reader_led), .power_led(power_led));
	tims_reader_model tims_reader_model_inst (.core_clk(core_clk), .rstn(rstn),
		.reader_start(reader_start), .lat(lat), .err(err), .tag(tag),
		.reader_done(reader_done), .reader_error(reader_error), .tag_in_field(tag_in_field));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	function automatic logic [15:0] rnd();
		lfsr_state = {lfsr_state[14:0],
			lfsr_state[15] ^ lfsr_state[13] ^ lfsr_state[12] ^ lfsr_state[10]};
		return lfsr_state;
	endfunction : rnd

	// Writes in the initialise positions become init operations, reserved positions start nothing.
	function automatic logic [1:0] exp_op(input logic [3:0] sw, input logic [1:0] cmd);
		if (sw > SW_INIT_ECC) return 2'h0;
		if (cmd == CMD_WRITE && sw >= SW_INIT) return 2'h3;
		return cmd;
	endfunction : exp_op

	task automatic chk(input logic ok, input string msg);
		n_compared++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask : chk

	task automatic conclude();
		if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : conclude

	// The request is left standing so a following call can run back to back.
	task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		// Only the watchdog ends this wait; read data is taken at the answering edge.
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
	endtask : av

	task automatic idle();
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask : idle

	task automatic run(input logic [3:0] sw, input logic [1:0] cmd, input logic sel, input logic e);
		mode_switch <= sw;
		av(1'b1, OFS_CTRL, {30'h0, sel, 1'b0});
		idle();
		repeat (4) @(posedge core_clk);
		chk(tester_enable === sw[3], "tester port");
		chk(host_frames_en === !sw[3], "host frames");
		chk(strict_check === (sw == SW_TEST || sw == SW_TEST_ECC), "strict");
		if (!sw[3]) chk(ecc_enable === (sw == 4'h1 || sw == 4'h3 || sw == 4'h5), "ecc");
		e_op = exp_op(sw, cmd);
		err <= e;
		lat <= 5'(16 + rnd() % 16);
		starts = 0;
		toggles = 0;
		av(1'b1, OFS_IMG_OUT, {30'h0, cmd});
		av(1'b1, OFS_IMG_OUT, {30'h0, CMD_NONE});
		idle();
		repeat (6) @(posedge core_clk);
		if (e_op != 2'h0)
			chk(second_reader_led === sel && first_reader_led === !sel, "reader led");
		repeat (40) @(posedge core_clk);
		chk(starts === ((e_op != 2'h0) ? 1 : 0), "start count");
		if (e_op != 2'h0) begin
			chk(seen_op === e_op, "operation");
			chk(error_led === e, "error led");
			chk(toggles > 0, "dialog flashing");
		end
	endtask : run

	always @(posedge core_clk) begin
		if (reader_start === 1'b1) begin
			starts++;
			seen_op = reader_op;
		end
		if (dialog_led !== dlast) toggles++;
		dlast = dialog_led;
		if (rstn) chk($onehot0({first_reader_led, second_reader_led}), "both reader leds");
	end

	initial begin
		#200000;
		fail_count++;
		conclude();
	end

	initial begin
		rstn = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hF;
		mode_switch = 4'h0;
		supply_24v_ok = 1'b1;
		hw_fault = 1'b0;
		lat = 5'h10;
		err = 1'b0;
		tag = 1'b0;
		lfsr_state = 16'h3F2A;
		fail_count = 0;
		n_compared = 0;
		dlast = 1'b0;
		repeat (20) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk(power_led === 1'b1, "power on");
		supply_24v_ok <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk(power_led === 1'b0, "power off");
		supply_24v_ok <= 1'b1;
		av(1'b0, OFS_FOOT, 32'h0000_0000);
		chk(rd === IMG_TOTAL, "footprint");
		av(1'b0, 8'hF0, 32'h0000_0000);
		chk(rd === 32'h0000_0000, "unmapped read");
		idle();
		// switch positions 0 to 15 each run a write; all but 4 and 5 also run a read.
		for (int s = 0; s < 16; s++) begin
			run(4'(s), CMD_WRITE, rnd() % 2, rnd() % 2);
			if (s != 4 && s != 5) run(4'(s), CMD_READ, rnd() % 2, 1'b0);
		end
		av(1'b1, OFS_IRQ_MSK, 32'h0000_0001 << EV_DONE);
		av(1'b0, OFS_IRQ_ST, 32'h0000_0000);
		idle();
		chk(irq === 1'b0, "irq before dialog");
		run(SW_NORMAL, CMD_READ, 1'b0, 1'b0);
		chk(irq === 1'b1, "irq raised");
		av(1'b0, OFS_IRQ_ST, 32'h0000_0000);
		chk(rd[EV_DONE] === 1'b1, "done event");
		idle();
		chk(irq === 1'b0, "irq cleared");
		av(1'b1, OFS_IRQ_MSK, 32'h0000_0000);
		idle();
		run(SW_TEST, CMD_READ, 1'b1, 1'b0);
		chk(irq === 1'b0, "irq masked");
		hw_fault <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk(error_led === 1'b1, "fault led");
		hw_fault <= 1'b0;
		av(1'b1, OFS_CTRL, 32'h0000_0001);
		idle();
		tag <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk(dialog_led === 1'b1, "steady with presence");
		chk(presence_led === 1'b1, "tag present");
		tag <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk(presence_led === 1'b0, "tag gone");
		rstn <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk(reader_start === 1'b0 && error_led === 1'b0, "mid reset");
		rstn <= 1'b1;
		av(1'b0, OFS_CTRL, 32'h0000_0000);
		chk(rd === CTRL_RESET, "control after reset");
		idle();
		repeat (2) @(posedge core_clk);
		chk(power_led === 1'b1, "power after reset");
		conclude();
	end
endmodule : tb
